// ===== verilog/cap_regs.svh
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH

// ==========================================================
// Register addresses
`define CAP_MD_ADDR        8'hd9
`define CAP_PWMCFG_ADDR    8'hda
`define CAP_STATUS_ADDR    8'hdb
`define CAP_CNTL_ADDR      8'hdc
`define CAP_CNTH_ADDR      8'hdd
`define CAP_MODE_BASE      8'he0
`define CAP_CPL_BASE       8'he8
`define CAP_CPH_BASE       8'hf0

// ==========================================================
// Counter mode register fields
`define CAP_MD_RESET       8'h40
`define CAP_MD_IDLE_SUSP   7
`define CAP_MD_WD_EN       6
`define CAP_MD_WD_LOCK     5
`define CAP_MD_UNUSED      4
`define CAP_MD_TB_HI       3
`define CAP_MD_TB_LO       1
`define CAP_MD_OVF_IE      0

// ==========================================================
// PWM configuration, status and module mode fields
`define CAP_PWM_VIEW_SEL   7
`define CAP_PWM_CYC_OVF    5
`define CAP_STAT_CNT_OVF   7
`define CAP_MODE_CMP_EN    6
`define CAP_MODE_MATCH_EN  3
`define CAP_MODE_PWM       1

// ==========================================================
// Timebase codes and divider counts
`define CAP_TB_DIV12       3'h0
`define CAP_TB_DIV4        3'h1
`define CAP_TB_T0          3'h2
`define CAP_TB_XIN         3'h3
`define CAP_TB_SYS         3'h4
`define CAP_TB_EXT8        3'h5
`define CAP_TB_LFO8        3'h6
`define CAP_DIV12_LAST     4'hb
`define CAP_DIV4_LAST      2'h3
`define CAP_DIV8_LAST      3'h7
`define CAP_XIN_GAP        2'h3

`endif

// ===== verilog/cap_pkg.sv
package cap_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cap_sfr_req_t;

  typedef struct packed {
    logic        tick;
    logic        ovf;
    logic        long_mode;
    logic [15:0] cnt_masked;
    logic [15:0] mask;
  } cap_chan_ctl_t;

  typedef struct packed {
    logic sel_mode;
    logic sel_low;
    logic sel_high;
    logic view_sel;
  } cap_chan_wr_t;

endpackage

// ===== verilog/cap_pwm_chan.sv
`timescale 1ns/1ns
`include "cap_regs.svh"

module cap_pwm_chan (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire cap_pkg::cap_chan_ctl_t ctl_i,
  input  wire cap_pkg::cap_chan_wr_t  wr_i,
  input  wire logic [7:0]           wdata_i,
  output logic [15:0]               cmp_o,
  output logic [15:0]               arl_o,
  output logic [7:0]                mode_o,
  output logic                      out_o,
  output logic                      evt_set_o
);
  import cap_pkg::*;

  logic active;
  logic match;

  assign active = mode_o[`CAP_MODE_CMP_EN] & mode_o[`CAP_MODE_PWM] & ctl_i.long_mode;
  assign match  = active & ctl_i.tick & (ctl_i.cnt_masked == (cmp_o & ctl_i.mask));

  // ==========================================================
  // Compare and reload registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_o <= 16'h0000;
    end else if (wr_i.sel_low && !wr_i.view_sel) begin
      cmp_o[7:0] <= wdata_i;
    end else if (wr_i.sel_high && !wr_i.view_sel) begin
      cmp_o[15:8] <= wdata_i;
    end else if (active && ctl_i.ovf) begin
      cmp_o <= arl_o;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arl_o <= 16'h0000;
    end else if (wr_i.sel_low && wr_i.view_sel) begin
      arl_o[7:0] <= wdata_i;
    end else if (wr_i.sel_high && wr_i.view_sel) begin
      arl_o[15:8] <= wdata_i;
    end
  end

  // ==========================================================
  // Mode register; byte writes steer the comparator enable
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= 8'h00;
    end else if (wr_i.sel_mode) begin
      mode_o <= wdata_i;
    end else if (wr_i.sel_low) begin
      mode_o[`CAP_MODE_CMP_EN] <= 1'b0;
    end else if (wr_i.sel_high) begin
      mode_o[`CAP_MODE_CMP_EN] <= 1'b1;
    end
  end

  // ==========================================================
  // Output; match beats overflow so a zero compare gives full duty
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_o <= 1'b0;
    end else if (!active) begin
      out_o <= 1'b0;
    end else if (match) begin
      out_o <= 1'b1;
    end else if (ctl_i.ovf) begin
      out_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_set_o <= 1'b0;
    end else begin
      evt_set_o <= match & mode_o[`CAP_MODE_MATCH_EN];
    end
  end

endmodule

// ===== verilog/cap_top.sv
// Overview of operation
// - Compare byte locations reach reload register when view select is 1, else compare.
// - Output goes high when low N counter bits equal the compare value.
// - Overflow from bit N drives output low, sets cycle flag, reloads compare.
// - Cycle length N comes from the cycle length select field.
// - Long PWM runs with comparator and pwm enables set and length not 8.
// - With match flag enable set, each match sets the module event flag.
// - Cycle overflow repeats every 512, 1024 or 2048 counter ticks.
// - Low byte write clears comparator enable; high byte write sets it.
// - Comparator enable cleared keeps the output low, zero duty.
// - Idle suspend set halts the counter during processor idle.
// - Watchdog enable makes module 2 the watchdog; resets to one.
// - Watchdog lock prevents clearing watchdog enable until reset.
// - Timebase select picks sysclk/12, /4, timer0, ext falls, sysclk, ext/8, lfo/8.
// - External count falling edges are counted at most once per four clocks.
// - Overflow interrupt enable gates the counter overflow flag to a request.
// - While watchdog enabled, counter mode bits other than enable and lock keep their value.
// - Counter mode bit 4 reads zero and ignores writes.
`timescale 1ns/1ns
`include "cap_regs.svh"

module cap_top #(
  parameter int NUM_MODULES = 3
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire cap_pkg::cap_sfr_req_t sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire logic                  idle_i,
  input  wire logic                  timer0_ovf_i,
  input  wire logic                  external_count_input_i,
  input  wire logic                  ext_clk_i,
  input  wire logic                  lfo_clk_i,
  output logic [NUM_MODULES-1:0]     module_output_pin_o,
  output logic                       irq_o,
  output logic                       watchdog_enable_o
);
  import cap_pkg::*;

  // Module 2 must exist for the watchdog; addresses allow eight modules
  if (NUM_MODULES < 3 || NUM_MODULES > 8) begin : g_bad_count
    $error("cap_top: NUM_MODULES must be 3 to 8");
  end

  // ==========================================================
  // Declarations
  logic [7:0]             md_r;
  logic [7:0]             md_nxt;
  logic                   view_sel_r;
  logic                   cyc_ovf_r;
  logic [1:0]             cyc_len_r;
  logic                   cnt_ovf_r;
  logic [NUM_MODULES-1:0] evt_r;
  logic [15:0]            cnt_r;
  logic [15:0]            cnt_nxt;
  logic [15:0]            mask;
  logic                   run;
  logic                   tick;
  logic                   cyc_ovf;
  logic [3:0]             div12_r;
  logic [1:0]             div4_r;
  logic                   xin_d_r;
  logic                   xin_fall;
  logic [1:0]             xin_gap_r;
  logic                   xin_tick;
  logic [1:0]             src_s1_r;
  logic [1:0]             src_s2_r;
  logic [1:0]             src_s3_r;
  logic [2:0]             div8_r [2];
  logic [1:0]             div8_tick;
  logic [2:0]             tbsel;
  logic [7:0]             rd_val;
  logic                   wr_md;
  logic                   wr_pwm;
  logic                   wr_stat;
  cap_chan_ctl_t          ctl;
  cap_chan_wr_t           chan_wr [NUM_MODULES];
  logic [15:0]            cmp     [NUM_MODULES];
  logic [15:0]            arl     [NUM_MODULES];
  logic [7:0]             mode    [NUM_MODULES];
  logic [NUM_MODULES-1:0] evt_set;

  assign tbsel   = md_r[`CAP_MD_TB_HI:`CAP_MD_TB_LO];
  assign wr_md   = sfr_req_i.wr && (sfr_req_i.addr == `CAP_MD_ADDR);
  assign wr_pwm  = sfr_req_i.wr && (sfr_req_i.addr == `CAP_PWMCFG_ADDR);
  assign wr_stat = sfr_req_i.wr && (sfr_req_i.addr == `CAP_STATUS_ADDR);

  // ==========================================================
  // Counter mode register
  always_comb begin
    md_nxt = md_r;
    if (wr_md) begin
      if (md_r[`CAP_MD_WD_EN]) begin
        md_nxt[`CAP_MD_WD_EN] = sfr_req_i.wdata[`CAP_MD_WD_EN] | md_r[`CAP_MD_WD_LOCK];
      end else begin
        md_nxt = sfr_req_i.wdata;
      end
      // Lock only sets; a later write must not reopen the enable
      md_nxt[`CAP_MD_WD_LOCK] = md_r[`CAP_MD_WD_LOCK] | sfr_req_i.wdata[`CAP_MD_WD_LOCK];
      md_nxt[`CAP_MD_UNUSED] = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      md_r <= `CAP_MD_RESET;
    end else begin
      md_r <= md_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_enable_o <= 1'b1;
    end else begin
      watchdog_enable_o <= md_nxt[`CAP_MD_WD_EN];
    end
  end

  // ==========================================================
  // PWM configuration
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      view_sel_r <= 1'b0;
      cyc_len_r  <= 2'h0;
    end else if (wr_pwm) begin
      view_sel_r <= sfr_req_i.wdata[`CAP_PWM_VIEW_SEL];
      cyc_len_r  <= sfr_req_i.wdata[1:0];
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_ovf_r <= 1'b0;
    end else if (cyc_ovf && cyc_len_r != 2'h0) begin
      cyc_ovf_r <= 1'b1;
    end else if (wr_pwm && !sfr_req_i.wdata[`CAP_PWM_CYC_OVF]) begin
      cyc_ovf_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ovf_r <= 1'b0;
    end else if (tick && cnt_r == 16'hffff) begin
      cnt_ovf_r <= 1'b1;
    end else if (wr_stat && !sfr_req_i.wdata[`CAP_STAT_CNT_OVF]) begin
      cnt_ovf_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_r <= '0;
    end else if (wr_stat) begin
      evt_r <= (evt_r & sfr_req_i.wdata[NUM_MODULES-1:0]) | evt_set;
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= cnt_ovf_r & md_r[`CAP_MD_OVF_IE];
    end
  end

  // ==========================================================
  // Timebase
  assign run = !(md_r[`CAP_MD_IDLE_SUSP] && idle_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div12_r <= 4'h0;
      div4_r  <= 2'h0;
    end else if (run) begin
      div12_r <= (div12_r == `CAP_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_r  <= div4_r + 2'h1;
    end
  end

  // Inputs are synchronous, so one register suffices for the edge
  assign xin_fall = xin_d_r & ~external_count_input_i;
  assign xin_tick = xin_fall && (xin_gap_r == 2'h0) && run;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xin_d_r   <= 1'b0;
      xin_gap_r <= 2'h0;
    end else begin
      xin_d_r <= external_count_input_i;
      if (xin_tick) begin
        xin_gap_r <= `CAP_XIN_GAP;
      end else if (xin_gap_r != 2'h0) begin
        xin_gap_r <= xin_gap_r - 2'h1;
      end
    end
  end

  // Free-running sources are resynchronised before their edges count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_s1_r <= 2'h0;
      src_s2_r <= 2'h0;
      src_s3_r <= 2'h0;
    end else begin
      src_s1_r <= {lfo_clk_i, ext_clk_i};
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_div8
    logic rise;
    assign rise         = src_s2_r[s] & ~src_s3_r[s] & run;
    assign div8_tick[s] = rise && (div8_r[s] == `CAP_DIV8_LAST);
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        div8_r[s] <= 3'h0;
      end else if (rise) begin
        div8_r[s] <= div8_r[s] + 3'h1;
      end
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (tbsel)
      `CAP_TB_DIV12: tick = run && (div12_r == `CAP_DIV12_LAST);
      `CAP_TB_DIV4:  tick = run && (div4_r == `CAP_DIV4_LAST);
      `CAP_TB_T0:    tick = run && timer0_ovf_i;
      `CAP_TB_XIN:   tick = xin_tick;
      `CAP_TB_SYS:   tick = run;
      `CAP_TB_EXT8:  tick = div8_tick[0];
      `CAP_TB_LFO8:  tick = div8_tick[1];
      default:       tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Counter and cycle length
  assign cnt_nxt = cnt_r + 16'h0001;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 16'h0000;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    mask = 16'h00ff;
    unique case (cyc_len_r)
      2'h0: mask = 16'h00ff;
      2'h1: mask = 16'h01ff;
      2'h2: mask = 16'h03ff;
      2'h3: mask = 16'h07ff;
    endcase
  end

  // Wrap of the low N bits is the cycle overflow, once per 2^N ticks
  assign cyc_ovf = tick && ((cnt_nxt & mask) == 16'h0000);

  assign ctl.tick       = tick;
  assign ctl.ovf        = cyc_ovf;
  assign ctl.long_mode  = (cyc_len_r != 2'h0);
  assign ctl.cnt_masked = cnt_nxt & mask;
  assign ctl.mask       = mask;

  // ==========================================================
  // Capture/compare modules
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
    assign chan_wr[m].sel_mode = sfr_req_i.wr && (sfr_req_i.addr == `CAP_MODE_BASE + 8'(m));
    assign chan_wr[m].sel_low  = sfr_req_i.wr && (sfr_req_i.addr == `CAP_CPL_BASE + 8'(m));
    assign chan_wr[m].sel_high = sfr_req_i.wr && (sfr_req_i.addr == `CAP_CPH_BASE + 8'(m));
    assign chan_wr[m].view_sel = view_sel_r;

    cap_pwm_chan u_chan (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .ctl_i     (ctl),
      .wr_i      (chan_wr[m]),
      .wdata_i   (sfr_req_i.wdata),
      .cmp_o     (cmp[m]),
      .arl_o     (arl[m]),
      .mode_o    (mode[m]),
      .out_o     (module_output_pin_o[m]),
      .evt_set_o (evt_set[m])
    );
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    unique case (sfr_req_i.addr)
      `CAP_MD_ADDR:     rd_val = md_r & ~8'h10;
      `CAP_PWMCFG_ADDR: rd_val = {view_sel_r, 1'b0, cyc_ovf_r, 3'h0, cyc_len_r};
      `CAP_STATUS_ADDR: rd_val = {cnt_ovf_r, 7'h00} | 8'(evt_r);
      `CAP_CNTL_ADDR:   rd_val = cnt_r[7:0];
      `CAP_CNTH_ADDR:   rd_val = cnt_r[15:8];
      default:          rd_val = 8'h00;
    endcase
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (sfr_req_i.addr == `CAP_MODE_BASE + 8'(i)) begin
        rd_val = mode[i];
      end
      if (sfr_req_i.addr == `CAP_CPL_BASE + 8'(i)) begin
        rd_val = view_sel_r ? arl[i][7:0] : cmp[i][7:0];
      end
      if (sfr_req_i.addr == `CAP_CPH_BASE + 8'(i)) begin
        rd_val = view_sel_r ? arl[i][15:8] : cmp[i][15:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd) begin
      sfr_rdata_o <= rd_val;
    end
  end

endmodule

// ===== verification/cap_properties.sv
`timescale 1ns/1ns
// ==========================================
// Port checker
module cap_chk #(
  parameter int NUM_MODULES = 3
) (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire cap_pkg::cap_sfr_req_t  sfr_req_i,
  input wire logic [7:0]             sfr_rdata_o,
  input wire logic [NUM_MODULES-1:0] module_output_pin_o,
  input wire logic                   irq_o,
  input wire logic                   watchdog_enable_o
);
  import cap_pkg::*;
  logic       lock_r;
  logic       cmp_en_r;
  logic [4:0] keep_r;
  wire        wr = sfr_req_i.wr;
  wire [7:0]  a = sfr_req_i.addr;
  wire [7:0]  wd = sfr_req_i.wdata;
  wire        md_wr = wr && a == 8'hd9;
  wire        md_rd = sfr_req_i.rd && a == 8'hd9;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Lock only sets; reset alone clears it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_r <= 1'b0;
    end else if (md_wr && wd[5]) begin
      lock_r <= 1'b1;
    end
  end

  // Bits other than enable and lock move only while watchdog is off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      keep_r <= 5'h00;
    end else if (md_wr && !watchdog_enable_o) begin
      keep_r <= {wd[7], wd[3:0]};
    end
  end

  // Comparator enable of module 0 as software left it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_en_r <= 1'b0;
    end else if (wr && a == 8'he0) begin
      cmp_en_r <= wd[6];
    end else if (wr && a == 8'he8) begin
      cmp_en_r <= 1'b0;
    end else if (wr && a == 8'hf0) begin
      cmp_en_r <= 1'b1;
    end
  end

  chk_md_bit4_zero: assert property (md_rd |=> !sfr_rdata_o[4])
    else $error("mode bit 4 read as one");
  chk_md_keep_bits: assert property (
    md_rd |=> {sfr_rdata_o[7], sfr_rdata_o[3:0]} == $past(keep_r))
    else $error("mode bits changed while watchdog on");
  chk_wd_lock_hold: assert property (lock_r && watchdog_enable_o |=> watchdog_enable_o)
    else $error("locked watchdog was disabled");
  chk_wd_clear_ok: assert property (
    md_wr && !lock_r && !wd[5] && !wd[6] |=> !watchdog_enable_o)
    else $error("watchdog enable did not clear");
  chk_wd_reset_on: assert property (!$past(resetn_i) |-> watchdog_enable_o)
    else $error("watchdog off after reset");
  chk_irq_needs_enable: assert property (md_rd ##1 irq_o |-> sfr_rdata_o[0])
    else $error("request raised while masked");
  chk_zero_duty: assert property (!cmp_en_r [*2] |-> !module_output_pin_o[0])
    else $error("output high with comparator off");
  chk_unmapped_zero: assert property (sfr_req_i.rd && a == 8'hd0 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfr_req_i.rd |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");

  cov_pwm_rise: cover property ($rose(module_output_pin_o[0]));
  cov_irq_rise: cover property ($rose(irq_o));
  cov_wd_off: cover property ($fell(watchdog_enable_o));
endmodule

bind cap_top cap_chk #(.NUM_MODULES(NUM_MODULES)) i_cap_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .module_output_pin_o(module_output_pin_o),
  .irq_o(irq_o), .watchdog_enable_o(watchdog_enable_o));

// ===== verification/cap_pwm_load.sv
`timescale 1ns/1ns
// ==========================================
// Load on one PWM pin, timing pulses in clocks
module cap_pwm_load (
  input  wire logic clk_i,
  input  wire logic pin_i,
  output int        rises_o,
  output int        period_o,
  output int        high_o
);
  int   cyc;
  int   t_rise;
  logic last;

  initial begin
    cyc = 0;
    t_rise = 0;
    last = 1'b0;
    rises_o = 0;
    period_o = 0;
    high_o = 0;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    last <= pin_i;
    if (pin_i === 1'b1 && last === 1'b0) begin
      if (rises_o > 0) period_o <= cyc - t_rise;
      t_rise <= cyc;
      rises_o <= rises_o + 1;
    end
    if (pin_i === 1'b0 && last === 1'b1) high_o <= cyc - t_rise;
  end
endmodule

// ===== verification/cap_top_bench.sv
`timescale 1ns/1ns
// ==========================================
// Bench
module cap_top_bench;
  import cap_pkg::*;
  logic         clk_i;
  logic         resetn_i;
  cap_sfr_req_t req;
  logic [7:0]   rdata;
  logic         idle_i;
  logic         t0_ovf;
  logic         xcnt;
  logic         ext_clk;
  logic         lfo_clk;
  logic [2:0]   pins;
  logic         irq;
  logic [31:0]  cyc;
  int           err_count;
  int           n_compared;
  int           rises;
  int           period;
  int           high;
  int           h;

  cap_top i_cap_top (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .idle_i(idle_i), .timer0_ovf_i(t0_ovf),
    .external_count_input_i(xcnt), .ext_clk_i(ext_clk), .lfo_clk_i(lfo_clk),
    .module_output_pin_o(pins), .irq_o(irq), .watchdog_enable_o());
  cap_pwm_load i_cap_pwm_load (.clk_i(clk_i), .pin_i(pins[0]), .rises_o(rises),
    .period_o(period), .high_o(high));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Count input falls once per 8 clocks, inside its limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    t0_ovf <= (cyc % 6 == 0);
    xcnt <= cyc[2];
    if (cyc % 5 == 0) ext_clk <= ~ext_clk;
    if (cyc % 7 == 0) lfo_clk <= ~lfo_clk;
  end

  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("got %h want %h", got, exp));
  endtask

  task automatic cmpn(input int got, input int exp);
    n_compared++;
    if (got != exp) fail($sformatf("measured %0d want %0d", got, exp));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
    @(posedge clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req <= '0;
    #1 dt = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] dt;
    rd(a, dt);
    cmp8(dt & m, e);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask

  // Bounded wait for n more pulses at the load
  task automatic wait_rises(input int n);
    int s;
    s = rises;
    for (int i = 0; i < 8000 && rises < s + n; i++) @(posedge clk_i);
    if (rises < s + n) begin
      fail("no pulses");
      complete_run();
    end
  endtask

  // Samples of pin p that are not at level lvl, unknowns included
  task automatic cnt_off(input int p, input logic lvl, input int n, output int hc);
    hc = 0;
    repeat (2) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      if (pins[p] !== lvl) hc++;
    end
  endtask

  // Counter advance over 480 clocks for one mode setting
  task automatic measure(input logic [7:0] md, input logic idl, input int lo, input int hi);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] df;
    wr(8'hd9, md);
    idle_i <= idl;
    rd(8'hdc, a);
    repeat (478) @(posedge clk_i);
    rd(8'hdc, b);
    idle_i <= 1'b0;
    df = b - a;
    cmp8({7'h00, df >= lo && df <= hi}, 8'h01);
  endtask

  initial begin
    #1_000_000;
    fail("run timeout");
    complete_run();
  end

  initial begin
    resetn_i = 1'b0;
    req = '0;
    idle_i = 1'b0;
    t0_ovf = 1'b0;
    xcnt = 1'b1;
    ext_clk = 1'b0;
    lfo_clk = 1'b0;
    cyc = 32'h0;
    err_count = 0;
    n_compared = 0;
    do_reset();
    rc(8'hd9, 8'hff, 8'h40);
    rc(8'hd0, 8'hff, 8'h00);
    wr(8'hd9, 8'hff);
    rc(8'hd9, 8'hff, 8'h60);
    wr(8'hd9, 8'h00);
    rc(8'hd9, 8'hff, 8'h60);
    do_reset();
    rc(8'hd9, 8'hff, 8'h40);
    wr(8'hd9, 8'h00);
    rc(8'hd9, 8'hff, 8'h00);
    wr(8'hd9, 8'h9f);
    rc(8'hd9, 8'hff, 8'h8f);
    wr(8'hd9, 8'h0e);
    rc(8'hd9, 8'hff, 8'h0e);
    $display("test mode register done");
    wr(8'he0, 8'h42);
    wr(8'he8, 8'h00);
    rc(8'he0, 8'hff, 8'h02);
    wr(8'hf0, 8'h01);
    rc(8'he0, 8'hff, 8'h42);
    wr(8'hda, 8'h81);
    wr(8'he8, 8'h80);
    wr(8'hf0, 8'h01);
    rc(8'he8, 8'hff, 8'h80);
    wr(8'hda, 8'h01);
    rc(8'he8, 8'hff, 8'h00);
    $display("test compare access done");
    wr(8'hd9, 8'h08);
    wr(8'he0, 8'h4a);
    wait_rises(3);
    cmpn(period, 512);
    cmpn(high, 128);
    rc(8'hda, 8'h20, 8'h20);
    rc(8'hdb, 8'h01, 8'h01);
    for (int l = 2; l < 4; l++) begin
      wr(8'hda, 8'(l));
      wait_rises(3);
      cmpn(period, 1 << (8 + l));
      cmpn(high, (1 << (8 + l)) - 384);
    end
    // Module 1 at compare zero runs full duty; module 2 lacks its pwm enable
    wr(8'he1, 8'h02);
    wr(8'he9, 8'h00);
    wr(8'hf1, 8'h00);
    wr(8'he2, 8'h40);
    repeat (2100) @(posedge clk_i);
    cnt_off(1, 1'b1, 600, h);
    cmpn(h, 0);
    cnt_off(2, 1'b0, 600, h);
    cmpn(h, 0);
    wr(8'hda, 8'h00);
    cnt_off(0, 1'b0, 600, h);
    cmpn(h, 0);
    wr(8'hda, 8'h01);
    wr(8'he8, 8'h80);
    cnt_off(0, 1'b0, 1100, h);
    cmpn(h, 0);
    $display("test pwm done");
    measure(8'h00, 1'b0, 40, 40);
    measure(8'h02, 1'b0, 120, 120);
    measure(8'h04, 1'b0, 80, 80);
    measure(8'h06, 1'b0, 60, 60);
    measure(8'h08, 1'b0, 224, 224);
    measure(8'h0a, 1'b0, 6, 6);
    measure(8'h0c, 1'b0, 4, 5);
    measure(8'h0e, 1'b0, 0, 0);
    measure(8'h88, 1'b1, 0, 0);
    measure(8'h08, 1'b1, 224, 224);
    $display("test timebase done");
    wr(8'hd9, 8'h09);
    for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge clk_i);
    cmp8({7'h00, irq}, 8'h01);
    rc(8'hd9, 8'hff, 8'h09);
    rc(8'hdb, 8'h80, 8'h80);
    wr(8'hd9, 8'h08);
    repeat (2) @(posedge clk_i);
    #1 cmp8({7'h00, irq}, 8'h00);
    wr(8'hdb, 8'h00);
    rc(8'hdb, 8'h80, 8'h00);
    $display("test overflow request done");
    complete_run();
  end
endmodule
